/* hdl/socket_state_pkg.sv */
// Constants for the socket present state register block.
// Assumes a single controller clock and a plain register port.
package socket_state_pkg;
    localparam logic [7:0] present_state_ofs = 8'h08;
    localparam logic [7:0] force_event_ofs = 8'h0c;
    localparam logic [7:0] irq_status_ofs = 8'h20;
    localparam logic [7:0] irq_mask_ofs = 8'h24;
    localparam logic [7:0] dev_ctrl_ofs = 8'h28;
    // Field positions in the present state word.
    localparam int volt_y_socket_bit = 31;
    localparam int volt_x_socket_bit = 30;
    localparam int socket_3v3_bit = 29;
    localparam int socket_5v0_bit = 28;
    localparam int card_volt_y_bit = 13;
    localparam int card_volt_x_bit = 12;
    localparam int card_3v3_bit = 11;
    localparam int card_5v0_bit = 10;
    localparam int bad_supply_bit = 9;
    localparam int data_loss_bit = 8;
    localparam int not_card_bit = 7;
    localparam int ready_irq_bit = 6;
    localparam int wide_card_bit = 5;
    localparam int narrow_card_bit = 4;
    localparam int powered_bit = 3;
    localparam int detect_b_bit = 2;
    localparam int detect_a_bit = 1;
    localparam int status_chg_bit = 0;
    // Force event extra bits, device control 5 V off bit and reset value; card fields share the present state positions.
    localparam int force_retest_bit = 14;
    localparam int force_socket_3v3_bit = 15;
    localparam int dev_ctrl_5v0_off_bit = 6;
    localparam logic [31:0] present_reset = 32'h3000_0000;
    // Interrupt status layout.
    localparam int ev_detect_bit = 0;
    localparam int ev_status_bit = 1;
    localparam int ev_power_bit = 2;
    localparam int ev_insert_bit = 3;
    localparam int ev_width = 4;
endpackage

/* hdl/card_socket_present_state.sv */
// Socket present state register with force event, device control and events.
// Assumes card pins asynchronous, register port synchronous to clk.
// Notes on behaviour
// - Low-voltage socket capability bits always read zero.
// - 3.3 V socket bit reads one unless the force event overrides it.
// - 5 V socket bit reads one unless device control bit 6 overrides.
// - Bits 27 to 14 read zero.
// - Card voltage bits report card support and are settable by force event.
// - Card voltage and type held except at insertion or a force event write.
// - Bad supply request flag set on invalid power request, reset zero.
// - Data loss flag set when removal may lose data, reset zero.
// - Unrecognised card flag set on bad card, kept until valid card or a force event write.
// - Bit 6 follows the ready/interrupt pin level.
// - Wide card bit shows CardBus card, changes only on interrogation or a force event write.
// - Narrow card bit shows 16-bit card, changes only on interrogation or a force event write.
// - Powered bit shows card power request state, reset zero.
// - Detect bits follow detect pins, frozen during interrogation.
// - Bit 0 follows the status change pin level.
// - Force event writes appear as if hardware detected them; here they load only the card, error and 3.3 V fields and raise no event.
// - Register at offset 08h, read only, reset 3000 00XXh.
`timescale 1ns/100ps
module card_socket_present_state (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic card_detect_pin_a,
    input wire logic card_detect_pin_b,
    input wire logic card_status_change_pin,
    input wire logic card_ready_pin,
    input wire logic interrogating,
    input wire logic interrog_done,
    input wire logic [3:0] sensed_volt,
    input wire logic sensed_wide,
    input wire logic sensed_narrow,
    input wire logic sensed_unrecognised,
    input wire logic invalid_request_evt,
    input wire logic data_loss_evt,
    input wire logic power_request,
    output logic irq
);
    // Two-stage synchronisers for the four card pins.
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= {card_ready_pin, card_status_change_pin,
                         card_detect_pin_b, card_detect_pin_a};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Detect levels are frozen while interrogation drives the detect pins.
    logic detect_pin_a_level;
    logic detect_pin_b_level;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            detect_pin_a_level <= 1'b1;
            detect_pin_b_level <= 1'b1;
        end else if (!interrogating) begin
            detect_pin_a_level <= pin_s2_r[0];
            detect_pin_b_level <= pin_s2_r[1];
        end
    end

    logic force_wr;
    logic ctrl_wr;
    assign force_wr = reg_wr && reg_addr == socket_state_pkg::force_event_ofs;
    assign ctrl_wr = reg_wr && reg_addr == socket_state_pkg::dev_ctrl_ofs;

    // Socket capability overrides.
    logic socket_3v3_off_r;
    logic socket_5v0_off_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            socket_3v3_off_r <= 1'b0;
            socket_5v0_off_r <= 1'b0;
        end else begin
            if (force_wr) begin
                socket_3v3_off_r <= reg_wdata[socket_state_pkg::force_socket_3v3_bit];
            end
            if (ctrl_wr) begin
                socket_5v0_off_r <= reg_wdata[socket_state_pkg::dev_ctrl_5v0_off_bit];
            end
        end
    end

    // Card voltage and type: loaded at end of interrogation or by force write.
    logic [3:0] card_volt_r;
    logic wide_card_detected;
    logic narrow_card_detected;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            card_volt_r <= 4'h0;
            wide_card_detected <= 1'b0;
            narrow_card_detected <= 1'b0;
        end else if (force_wr) begin
            card_volt_r <= reg_wdata[socket_state_pkg::card_volt_y_bit:
                                     socket_state_pkg::card_5v0_bit];
            wide_card_detected <= reg_wdata[socket_state_pkg::wide_card_bit];
            narrow_card_detected <= reg_wdata[socket_state_pkg::narrow_card_bit];
        end else if (interrog_done) begin
            card_volt_r <= sensed_volt;
            wide_card_detected <= sensed_wide;
            narrow_card_detected <= sensed_narrow;
        end
    end

    // Error flags; a hardware event wins over a forced value in the same cycle.
    logic invalid_supply_request;
    logic removal_data_loss;
    logic unrecognised_card;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            invalid_supply_request <= 1'b0;
            removal_data_loss <= 1'b0;
            unrecognised_card <= 1'b0;
        end else begin
            if (invalid_request_evt) begin
                invalid_supply_request <= 1'b1;
            end else if (force_wr) begin
                invalid_supply_request <= reg_wdata[socket_state_pkg::bad_supply_bit];
            end
            if (data_loss_evt) begin
                removal_data_loss <= 1'b1;
            end else if (force_wr) begin
                removal_data_loss <= reg_wdata[socket_state_pkg::data_loss_bit];
            end
            if (interrog_done && sensed_unrecognised) begin
                unrecognised_card <= 1'b1;
            end else if (interrog_done) begin
                unrecognised_card <= 1'b0;
            end else if (force_wr) begin
                unrecognised_card <= reg_wdata[socket_state_pkg::not_card_bit];
            end
        end
    end

    // Power state register mirrors the power request.
    logic socket_powered;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            socket_powered <= 1'b0;
        end else begin
            socket_powered <= power_request;
        end
    end

    // Assemble the read-only word; unused fields stay zero.
    logic [31:0] present_word;
    always_comb begin
        present_word = 32'h0000_0000;
        present_word[socket_state_pkg::volt_y_socket_bit] = 1'b0;
        present_word[socket_state_pkg::volt_x_socket_bit] = 1'b0;
        present_word[socket_state_pkg::socket_3v3_bit] = !socket_3v3_off_r;
        present_word[socket_state_pkg::socket_5v0_bit] = !socket_5v0_off_r;
        present_word[socket_state_pkg::card_volt_y_bit:socket_state_pkg::card_5v0_bit] =
            card_volt_r;
        present_word[socket_state_pkg::bad_supply_bit] = invalid_supply_request;
        present_word[socket_state_pkg::data_loss_bit] = removal_data_loss;
        present_word[socket_state_pkg::not_card_bit] = unrecognised_card;
        present_word[socket_state_pkg::ready_irq_bit] = pin_s2_r[3];
        present_word[socket_state_pkg::wide_card_bit] = wide_card_detected;
        present_word[socket_state_pkg::narrow_card_bit] = narrow_card_detected;
        present_word[socket_state_pkg::powered_bit] = socket_powered;
        present_word[socket_state_pkg::detect_b_bit] = detect_pin_b_level;
        present_word[socket_state_pkg::detect_a_bit] = detect_pin_a_level;
        present_word[socket_state_pkg::status_chg_bit] = pin_s2_r[2];
    end

    // Events: detect change, status change, power change, interrogation done.
    logic [3:0] ev_status_r;
    logic [3:0] ev_mask_r;
    logic [3:0] ev_set;
    logic prev_detect_r;
    logic prev_status_r;
    logic prev_power_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_detect_r <= 1'b1;
            prev_status_r <= 1'b0;
            prev_power_r <= 1'b0;
        end else begin
            prev_detect_r <= detect_pin_a_level & detect_pin_b_level;
            prev_status_r <= pin_s2_r[2];
            prev_power_r <= socket_powered;
        end
    end
    always_comb begin
        ev_set = 4'h0;
        ev_set[socket_state_pkg::ev_detect_bit] =
            prev_detect_r != (detect_pin_a_level & detect_pin_b_level);
        ev_set[socket_state_pkg::ev_status_bit] = prev_status_r != pin_s2_r[2];
        ev_set[socket_state_pkg::ev_power_bit] = prev_power_r != socket_powered;
        ev_set[socket_state_pkg::ev_insert_bit] = interrog_done;
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ev_status_r <= 4'h0;
            ev_mask_r <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == socket_state_pkg::irq_status_ofs) begin
                ev_status_r <= (ev_status_r & ~reg_wdata[3:0]) | ev_set;
            end else begin
                ev_status_r <= ev_status_r | ev_set;
            end
            if (reg_wr && reg_addr == socket_state_pkg::irq_mask_ofs) begin
                ev_mask_r <= reg_wdata[3:0];
            end
        end
    end
    assign irq = |(ev_status_r & ev_mask_r);

    // Read port: data one cycle after the strobe; present state ignores writes.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                socket_state_pkg::present_state_ofs: reg_rdata <= present_word;
                socket_state_pkg::irq_status_ofs: reg_rdata <= {28'h0, ev_status_r};
                socket_state_pkg::irq_mask_ofs: reg_rdata <= {28'h0, ev_mask_r};
                socket_state_pkg::dev_ctrl_ofs:
                    reg_rdata <= {25'h0, socket_5v0_off_r, 6'h0};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // card_socket_present_state

/* dv/present_state_assertions.sv */
// Checker for the socket present state block, bound to its ports.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/100ps
module present_state_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic card_status_change_pin,
    input wire logic card_ready_pin,
    input wire logic interrog_done,
    input wire logic [3:0] sensed_volt,
    input wire logic sensed_wide,
    input wire logic sensed_narrow,
    input wire logic sensed_unrecognised,
    input wire logic invalid_request_evt,
    input wire logic data_loss_evt
);
    logic [2:0] up_r;
    wire logic rd_ps = reg_rd && (reg_addr == socket_state_pkg::present_state_ofs);
    wire logic quiet = !interrog_done && !reg_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Pin history from before release is not trusted until the synchroniser has refilled.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h7) begin
            up_r <= up_r + 3'h1;
        end
    end
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    a_fixed_zero: assert property (rd_ps |=> reg_rdata[31:30] == 2'h0
        && reg_rdata[27:14] == 14'h0) else $error("fixed bits nonzero");
    a_ready_level: assert property (rd_ps && up_r > 3'h4 && $stable(card_ready_pin)
        && card_ready_pin == $past(card_ready_pin, 2) && card_ready_pin == $past(card_ready_pin, 3)
        |=> reg_rdata[6] == $past(card_ready_pin)) else $error("ready bit wrong");
    a_status_level: assert property (rd_ps && up_r > 3'h4 && $stable(card_status_change_pin)
        && card_status_change_pin == $past(card_status_change_pin, 3)
        && card_status_change_pin == $past(card_status_change_pin, 2)
        |=> reg_rdata[0] == $past(card_status_change_pin)) else $error("status bit wrong");
    a_unmapped_zero: assert property (reg_rd
        && !(reg_addr inside {8'h08, 8'h0c, 8'h20, 8'h24, 8'h28}) |=> reg_rdata == 32'h0)
        else $error("unmapped read nonzero");
    a_error_flags: assert property ((invalid_request_evt || data_loss_evt) && !reg_wr
        ##1 !reg_wr ##1 rd_ps && !reg_wr |=> (reg_rdata[9:8]
        & $past({invalid_request_evt, data_loss_evt}, 3))
        == $past({invalid_request_evt, data_loss_evt}, 3)) else $error("error flag not set");
    a_probe_loads: assert property (interrog_done && !reg_wr ##1 quiet
        ##1 rd_ps && quiet |=> reg_rdata[13:10] == $past(sensed_volt, 3)
        && reg_rdata[7] == $past(sensed_unrecognised, 3)
        && reg_rdata[5:4] == {$past(sensed_wide, 3), $past(sensed_narrow, 3)})
        else $error("probe result not loaded");
    a_card_held: assert property (rd_ps && quiet ##1 rd_ps && quiet
        |=> (reg_rdata & 32'h3cb0) == ($past(reg_rdata) & 32'h3cb0)) else $error("card bits moved");
endmodule // present_state_checker
bind card_socket_present_state present_state_checker chk_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .card_status_change_pin(card_status_change_pin), .card_ready_pin(card_ready_pin),
    .interrog_done(interrog_done), .sensed_volt(sensed_volt), .sensed_wide(sensed_wide),
    .sensed_narrow(sensed_narrow), .sensed_unrecognised(sensed_unrecognised),
    .invalid_request_evt(invalid_request_evt), .data_loss_evt(data_loss_evt));

/* dv/card_model.sv */
// Behavioural card in the socket, plus the interrogation handshake.
// Assumes the bench sets ready and status levels; detect and ready pins pull up.
`timescale 1ns/100ps
module card_model (
    input wire logic clk,
    input wire logic ready_lvl,
    input wire logic sts_lvl,
    output logic pin_a,
    output logic pin_b,
    output logic pin_rdy,
    output logic pin_sts,
    output logic probing,
    output logic done,
    output logic [6:0] res
);
    logic inserted = 1'b0;
    // With no card the pull-ups win, so an empty socket never shows stale levels.
    assign pin_a = !inserted;
    assign pin_b = !inserted;
    assign pin_rdy = inserted ? ready_lvl : 1'b1;
    assign pin_sts = inserted && sts_lvl;
    initial begin
        probing = 1'b0;
        done = 1'b0;
        res = 7'h0;
    end
    // Detect pins move mid-probe; the result is only valid in the done cycle.
    task automatic insert(input logic [6:0] r);
        @(posedge clk);
        probing <= 1'b1;
        repeat (3) @(posedge clk);
        inserted <= 1'b1;
        repeat (8) @(posedge clk);
        res <= r;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        probing <= 1'b0;
        res <= ~r;
    endtask
endmodule // card_model

/* dv/testbench.sv */
// Bench for the socket present state block: register tasks and card scenarios.
// Assumes card_model stands in for both the card and the interrogation sequencer.
`timescale 1ns/100ps
module testbench;
    logic clk, sys_rst, reg_wr, reg_rd, rdy, sts, inv, loss, pwr, irq, pa, pb, pr, ps, prb, dn;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [6:0] res;
    int err_total = 0;
    int comparisons = 0;
    card_model card (.clk(clk), .ready_lvl(rdy), .sts_lvl(sts), .pin_a(pa), .pin_b(pb),
        .pin_rdy(pr), .pin_sts(ps), .probing(prb), .done(dn), .res(res));
    card_socket_present_state dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .card_detect_pin_a(pa), .card_detect_pin_b(pb), .card_status_change_pin(ps),
        .card_ready_pin(pr), .interrogating(prb), .interrog_done(dn), .sensed_volt(res[6:3]),
        .sensed_wide(res[2]), .sensed_narrow(res[1]), .sensed_unrecognised(res[0]),
        .invalid_request_evt(inv), .data_loss_evt(loss), .power_request(pwr), .irq(irq));
    // Clock at 8 ns.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic results;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hang is cut short well past the expected run of under a hundred cycles.
    initial begin
        #30000;
        err_total++;
        results();
    end
    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, rdy, sts, inv, loss, pwr} = 7'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
        rd(8'h08);
        chk(d, 32'h3000_0046);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08);
        chk(d, 32'h3000_0046);
        rd(8'h40);
        chk(d, 32'h0);
        fork
            card.insert(7'h14);
            begin
                repeat (8) @(posedge clk);
                rd(8'h08);
                chk(d & 32'h6, 32'h6);
            end
        join
        rd(8'h08);
        chk(d & 32'h3ff0, 32'h0820);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= 8'h08;
        repeat (2) @(posedge clk);
        reg_rd <= 1'b0;
        {rdy, sts, pwr} <= 3'h7;
        repeat (5) @(posedge clk);
        rd(8'h08);
        chk(d, 32'h3000_0869);
        // Event pulses are launched on a rising edge like every other input.
        @(posedge clk);
        {inv, loss} <= 2'h3;
        @(posedge clk);
        {inv, loss} <= 2'h0;
        rd(8'h08);
        chk(d, 32'h3000_0b69);
        wr(8'h0c, 32'h0000_b090);
        rd(8'h08);
        chk(d, 32'h1000_30d9);
        wr(8'h28, 32'h0000_0040);
        rd(8'h08);
        chk(d, 32'h0000_30d9);
        wr(8'h20, 32'hffff_ffff);
        card.insert(7'h01);
        rd(8'h08);
        chk(d & 32'h3ff0, 32'h00c0);
        chk(32'(irq), 32'h0);
        wr(8'h24, 32'h0000_0008);
        chk(32'(irq), 32'h1);
        rd(8'h20);
        chk(d & 32'h8, 32'h8);
        wr(8'h20, 32'h0000_0008);
        chk(32'(irq), 32'h0);
        card.insert(7'h0a);
        rd(8'h08);
        chk(d & 32'h3ff0, 32'h0450);
        chk(32'(irq), 32'h1);
        results();
    end
endmodule // testbench
